// ### lor_readback.sv
// configuration readback command handler with apb access to the settings
// assumes a lin link layer delivers master frames and response headers as pulses
// Notes on behaviour
// (RL1) report settings in halves, codes 04/05
// (RL2) master makes one exchange per half
// (RL3) request 3C, answer in 7D response
// (RL4) request: 80, command, address, fill, checksum; the handler does not check the fill bytes
// (RL5) half1 byte5: lock1, restriction, address
// (RL6) half1 bytes6-8: a11, a12, a13
// (RL7) half2 bytes2-7 coefficients, byte1 address
// (RL8) half2 byte8: lock2, modf, 1, thc, group
// (RL9) restriction keeps only colour and brightness
// (RL10) half1 bytes2-4 option encoding
`timescale 1ns/1ns
module lor_readback #(
    parameter logic [7:0] SHORT_COLOR_PID = 8'h01,
    parameter logic [7:0] BRIGHTNESS_PID = 8'h02
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    input wire lor_pkg::lor_frame_t req_frame,
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_pid,
    output logic tx_valid,
    output logic [63:0] tx_data,
    output logic [7:0] tx_csum,
    output logic fwd_valid,
    output lor_pkg::lor_frame_t fwd_frame
);
    typedef enum logic {LOR_IDLE, LOR_ARMED} lor_state_t;

    // classic checksum: inverted carry-wrapped sum of data bytes
    function automatic logic [7:0] lor_csum(input logic [63:0] d);
        logic [8:0] s;
        s = 9'h000;
        for (int i = 0; i < 8; i++) begin
            s = {1'b0, s[7:0]} + {1'b0, d[i*8 +: 8]};
            s = {1'b0, s[7:0]} + {8'h00, s[8]};
        end
        return ~s[7:0];
    endfunction : lor_csum

    lor_pkg::lor_cfg_t cfg_r, cfg_nxt;
    logic [7:0] coef_r [9];
    logic [7:0] coef_nxt [9];
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [7:0] served_r, served_nxt, ignored_r, ignored_nxt;
    lor_state_t state_r, state_nxt;
    logic half_r, half_nxt;
    logic tx_valid_r, tx_valid_nxt;
    logic [63:0] tx_data_r, tx_data_nxt;
    logic [7:0] tx_csum_r, tx_csum_nxt;
    logic fwd_valid_r, fwd_valid_nxt;
    lor_pkg::lor_frame_t fwd_frame_r, fwd_frame_nxt;
    logic apb_acc, allowed, is_req, addr_ok;
    logic [63:0] half1, half2;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;
    assign tx_csum = tx_csum_r;
    assign fwd_valid = fwd_valid_r;
    assign fwd_frame = fwd_frame_r;

    // one wait state, then the access completes
    assign apb_acc = psel && penable && !pready_r;

    always_comb begin
        cfg_nxt = cfg_r;
        coef_nxt = coef_r;
        prdata_nxt = 32'h00000000;
        pslverr_nxt = 1'b0;
        pready_nxt = apb_acc;
        if (apb_acc) begin
            case (paddr)
                lor_pkg::LOR_OFS_CFG: begin
                    if (pwrite) cfg_nxt = pwdata[19:0];
                    prdata_nxt = {12'h000, cfg_r};
                end
                lor_pkg::LOR_OFS_COEF_A: begin
                    if (pwrite) {coef_nxt[3], coef_nxt[2], coef_nxt[1], coef_nxt[0]} = pwdata;
                    prdata_nxt = {coef_r[3], coef_r[2], coef_r[1], coef_r[0]};
                end
                lor_pkg::LOR_OFS_COEF_B: begin
                    if (pwrite) {coef_nxt[7], coef_nxt[6], coef_nxt[5], coef_nxt[4]} = pwdata;
                    prdata_nxt = {coef_r[7], coef_r[6], coef_r[5], coef_r[4]};
                end
                lor_pkg::LOR_OFS_COEF_C: begin
                    if (pwrite) coef_nxt[8] = pwdata[7:0];
                    prdata_nxt = {24'h000000, coef_r[8]};
                end
                lor_pkg::LOR_OFS_STATUS: begin
                    prdata_nxt = {14'h0, half_r, state_r == LOR_ARMED, ignored_r, served_r};
                end
                default: begin
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= lor_pkg::LOR_CFG_RST;
            for (int i = 0; i < 9; i++) coef_r[i] <= lor_pkg::LOR_COEF_RST;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            coef_r <= coef_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // (RL10) half1 option byte encoding
    // (RL5) half1 lock, restriction, address
    // (RL6) half1 row-one coefficients
    assign half1 = {coef_r[2], coef_r[1], coef_r[0],
        cfg_r.first_lock_bit, cfg_r.command_restriction_bit, cfg_r.node_address,
        cfg_r.default_option, cfg_r.error_report_disable, cfg_r.thermal_warning_level, 5'h1F,
        lor_pkg::LOR_FILL,
        6'h3F, cfg_r.slow_bitrate, cfg_r.diagnostics_disable,
        lor_pkg::LOR_ADDR_TOP | {2'b00, cfg_r.node_address}};
    // (RL8) half2 status byte
    // (RL7) half2 address and coefficients
    assign half2 = {cfg_r.second_lock_bit, cfg_r.modulation_frequency_option, 1'b1,
        cfg_r.threshold_control_option, cfg_r.group_number,
        coef_r[8], coef_r[7], coef_r[6], coef_r[5], coef_r[4], coef_r[3],
        lor_pkg::LOR_ADDR_TOP | {2'b00, cfg_r.node_address}};

    // (RL9) restriction passes only colour and brightness
    assign allowed = !cfg_r.command_restriction_bit || req_frame.pid == SHORT_COLOR_PID
        || req_frame.pid == BRIGHTNESS_PID;
    assign addr_ok = req_frame.data[23:16] == (lor_pkg::LOR_ADDR_TOP | {2'b00, cfg_r.node_address});
    // (RL4) request id, checksum, 80, command and address checked before it is taken; fill bytes are not checked
    assign is_req = req_frame.pid == lor_pkg::LOR_REQ_PID && req_frame.csum_ok
        && req_frame.data[7:0] == lor_pkg::LOR_APP_CMD && req_frame.data[15] && addr_ok
        && (req_frame.data[14:8] == lor_pkg::LOR_CMD_HALF1
        || req_frame.data[14:8] == lor_pkg::LOR_CMD_HALF2);

    always_comb begin
        state_nxt = state_r;
        half_nxt = half_r;
        served_nxt = served_r;
        ignored_nxt = ignored_r;
        tx_valid_nxt = 1'b0;
        tx_data_nxt = tx_data_r;
        tx_csum_nxt = tx_csum_r;
        fwd_valid_nxt = 1'b0;
        fwd_frame_nxt = fwd_frame_r;
        case (state_r)
            LOR_IDLE, LOR_ARMED: begin
                // (RL3) answer only the slave response header
                if (state_r == LOR_ARMED && hdr_valid && hdr_pid == lor_pkg::LOR_RESP_PID) begin
                    tx_valid_nxt = 1'b1;
                    tx_data_nxt = half_r ? half2 : half1;
                    tx_csum_nxt = lor_csum(half_r ? half2 : half1);
                    served_nxt = served_r + 8'h01;
                    state_nxt = LOR_IDLE;
                end
                if (req_valid) begin
                    state_nxt = LOR_IDLE;
                    if (!allowed) begin
                        ignored_nxt = ignored_r + 8'h01;
                    end else if (is_req) begin
                        // (RL1) command code picks the half
                        half_nxt = req_frame.data[14:8] == lor_pkg::LOR_CMD_HALF2;
                        state_nxt = LOR_ARMED;
                    end else begin
                        fwd_valid_nxt = 1'b1;
                        fwd_frame_nxt = req_frame;
                    end
                end
            end
            default: begin
                state_nxt = LOR_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= LOR_IDLE;
            half_r <= 1'b0;
            served_r <= 8'h00;
            ignored_r <= 8'h00;
            tx_valid_r <= 1'b0;
            tx_data_r <= 64'h0000000000000000;
            tx_csum_r <= 8'h00;
            fwd_valid_r <= 1'b0;
            fwd_frame_r <= '0;
        end else begin
            state_r <= state_nxt;
            half_r <= half_nxt;
            served_r <= served_nxt;
            ignored_r <= ignored_nxt;
            tx_valid_r <= tx_valid_nxt;
            tx_data_r <= tx_data_nxt;
            tx_csum_r <= tx_csum_nxt;
            fwd_valid_r <= fwd_valid_nxt;
            fwd_frame_r <= fwd_frame_nxt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    arm_on_req_a: assert property (req_valid && allowed && is_req |=> state_r == LOR_ARMED) // RL1
        else $error("valid readback request not armed");
    resp_pid_a: assert property (tx_valid_r |-> $past(hdr_pid) == lor_pkg::LOR_RESP_PID) // RL3
        else $error("response sent for wrong header");
    resp_half_a: assert property ( // RL1
        tx_valid_r |-> tx_data_r == ($past(half_r) ? $past(half2) : $past(half1)))
        else $error("response half mismatch");
    half1_lock_a: assert property ( // RL5
        tx_valid_r && !$past(half_r) |-> tx_data_r[39:32]
        == {$past(cfg_r.first_lock_bit), $past(cfg_r.command_restriction_bit),
        $past(cfg_r.node_address)})
        else $error("half1 byte5 wrong");
    half1_row_a: assert property ( // RL6
        tx_valid_r && !$past(half_r) |-> tx_data_r[47:40]
        == $past(coef_r[0]) && tx_data_r[63:56] == $past(coef_r[2]))
        else $error("half1 coefficients wrong");
    half2_coef_a: assert property ( // RL7
        tx_valid_r && $past(half_r) |-> tx_data_r[15:8]
        == $past(coef_r[3]) && tx_data_r[7:6] == 2'b11)
        else $error("half2 coefficients wrong");
    half2_last_a: assert property ( // RL8
        tx_valid_r && $past(half_r) |-> tx_data_r[61] == 1'b1
        && tx_data_r[59:56] == $past(cfg_r.group_number))
        else $error("half2 byte8 wrong");
    restrict_drop_a: assert property ( // RL9
        req_valid && !allowed |=> !fwd_valid_r
        && state_r == LOR_IDLE && ignored_r == $past(ignored_r) + 8'h01)
        else $error("restricted command acted upon");
    half1_opt_a: assert property ( // RL10
        tx_valid_r && !$past(half_r) |-> tx_data_r[23:16] == 8'hFF
        && tx_data_r[15:10] == 6'h3F && tx_data_r[28:24] == 5'h1F)
        else $error("half1 option bytes wrong");
    resp_csum_a: assert property (tx_valid_r |-> tx_csum_r == lor_csum(tx_data_r)) // RL3
        else $error("response checksum wrong");
    apb_ready_a: assert property (psel && penable && !pready_r |=> pready_r ##1 !pready_r)
        else $error("apb ready not one pulse");
endmodule : lor_readback

// ### lor_pkg.sv
// constants and carrier types for the configuration readback handler
// assumes frames arrive already split into protected id, data and checksum status
package lor_pkg;
    localparam logic [7:0] LOR_REQ_PID = 8'h3C;
    localparam logic [7:0] LOR_RESP_PID = 8'h7D;
    localparam logic [7:0] LOR_APP_CMD = 8'h80;
    localparam logic [6:0] LOR_CMD_HALF1 = 7'h04;
    localparam logic [6:0] LOR_CMD_HALF2 = 7'h05;
    localparam logic [7:0] LOR_FILL = 8'hFF;
    localparam logic [7:0] LOR_ADDR_TOP = 8'hC0;
    // apb byte addresses
    localparam logic [7:0] LOR_OFS_CFG = 8'h00;
    localparam logic [7:0] LOR_OFS_COEF_A = 8'h04;
    localparam logic [7:0] LOR_OFS_COEF_B = 8'h08;
    localparam logic [7:0] LOR_OFS_COEF_C = 8'h0C;
    localparam logic [7:0] LOR_OFS_STATUS = 8'h10;
    // configuration word field positions
    localparam int LOR_CFG_ADDR_LSB = 0;
    localparam int LOR_CFG_RESTRICT = 6;
    localparam int LOR_CFG_LOCK1 = 7;
    localparam int LOR_CFG_SLOW = 8;
    localparam int LOR_CFG_DIAG_OFF = 9;
    localparam int LOR_CFG_DEFAULT = 10;
    localparam int LOR_CFG_ERR_OFF = 11;
    localparam int LOR_CFG_TW = 12;
    localparam int LOR_CFG_LOCK2 = 13;
    localparam int LOR_CFG_MODF = 14;
    localparam int LOR_CFG_THC = 15;
    localparam int LOR_CFG_GROUP_LSB = 16;
    localparam logic [19:0] LOR_CFG_RST = 20'h00000;
    localparam logic [7:0] LOR_COEF_RST = 8'h00;

    typedef struct packed {
        logic [3:0] group_number;
        logic threshold_control_option;
        logic modulation_frequency_option;
        logic second_lock_bit;
        logic thermal_warning_level;
        logic error_report_disable;
        logic default_option;
        logic diagnostics_disable;
        logic slow_bitrate;
        logic first_lock_bit;
        logic command_restriction_bit;
        logic [5:0] node_address;
    } lor_cfg_t;

    typedef struct packed {
        logic [7:0] pid;
        logic [63:0] data;
        logic csum_ok;
    } lor_frame_t;
endpackage : lor_pkg

// ### lor_lin_master.sv
// lin master model: request frames and response headers for the readback handler
// assumes the link layer is abstracted to one-cycle frame and header pulses
`timescale 1ns/1ns
module lor_lin_master (
    input wire logic pclk,
    output logic req_valid,
    output lor_pkg::lor_frame_t req_frame,
    output logic hdr_valid,
    output logic [7:0] hdr_pid
);
    initial begin
        req_valid = 1'b0;
        req_frame = '0;
        hdr_valid = 1'b0;
        hdr_pid = 8'h00;
    end

    // frame lines show inverted data once released
    task send_frame(input logic [7:0] pid, input logic [63:0] d, input logic ok);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_frame <= '{pid: pid, data: d, csum_ok: ok};
        @(posedge pclk);
        req_valid <= 1'b0;
        req_frame <= ~req_frame;
    endtask : send_frame

    task send_readback(input logic [6:0] code, input logic [5:0] addr);
        send_frame(lor_pkg::LOR_REQ_PID, {{5{lor_pkg::LOR_FILL}}, 2'b11, addr, 1'b1, code,
            lor_pkg::LOR_APP_CMD}, 1'b1);
    endtask : send_readback

    task send_hdr(input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        hdr_valid <= 1'b1;
        hdr_pid <= lor_pkg::LOR_RESP_PID;
        @(posedge pclk);
        hdr_valid <= 1'b0;
        hdr_pid <= ~hdr_pid;
    endtask : send_hdr
endmodule : lor_lin_master

// ### tb_lin_otp_settings_readback.sv
// testbench for the configuration readback handler
// assumes the lin master model and apb tasks below are the only drivers
`timescale 1ns/1ns
module tb_lin_otp_settings_readback;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, req_valid, hdr_valid, tx_valid, fwd_valid, er;
    logic [7:0] hdr_pid, tx_csum;
    logic [63:0] tx_data, e1, e2;
    lor_pkg::lor_frame_t req_frame, fwd_frame;
    lor_pkg::lor_cfg_t cfg;
    int err_total = 0, n_tests = 0, cyc = 0;

    always #5 pclk = ~pclk;

    lor_readback dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .req_valid(req_valid), .req_frame(req_frame),
        .hdr_valid(hdr_valid), .hdr_pid(hdr_pid), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_csum(tx_csum), .fwd_valid(fwd_valid), .fwd_frame(fwd_frame));
    lor_lin_master u_master (.pclk(pclk), .req_valid(req_valid), .req_frame(req_frame),
        .hdr_valid(hdr_valid), .hdr_pid(hdr_pid));

    task end_of_test;
        $display("mismatches %0d of %0d comparisons", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test

    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] csum(input logic [63:0] d);
        int s;
        s = 0;
        for (int i = 0; i < 8; i++) begin
            s += d[i*8+:8];
            if (s > 255) s -= 255;
        end
        return ~s[7:0];
    endfunction : csum

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // collects tx and forward pulses over a few cycles
    task see(output logic tv, output logic fv);
        tv = 1'b0;
        fv = 1'b0;
        repeat (4) begin
            @(posedge pclk);
            tv = tv | tx_valid;
            fv = fv | fwd_valid;
        end
    endtask : see

    task t_regs;
        apb(1'b0, lor_pkg::LOR_OFS_CFG, 32'h0);
        chk(rd, 64'(lor_pkg::LOR_CFG_RST));
        apb(1'b1, lor_pkg::LOR_OFS_CFG, {12'h000, cfg});
        apb(1'b1, lor_pkg::LOR_OFS_COEF_A, 32'h21131211);
        apb(1'b1, lor_pkg::LOR_OFS_COEF_B, 32'h32312322);
        apb(1'b1, lor_pkg::LOR_OFS_COEF_C, 32'h00000033);
        apb(1'b0, lor_pkg::LOR_OFS_CFG, 32'h0);
        chk(rd, {44'h0, cfg});
        apb(1'b1, lor_pkg::LOR_OFS_STATUS, 32'hFFFFFFFF);
        chk(er, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
    endtask : t_regs

    task t_half(input logic [6:0] code, input int gap, input logic [63:0] exp);
        logic tv, fv;
        u_master.send_readback(code, cfg.node_address);
        apb(1'b0, lor_pkg::LOR_OFS_STATUS, 32'h0);
        chk(rd[17:16], {code == lor_pkg::LOR_CMD_HALF2, 1'b1});
        u_master.send_hdr(gap);
        see(tv, fv);
        chk({tv, fv}, 2'b10);
        chk(tx_data, exp);
        chk(tx_csum, csum(exp));
    endtask : t_half

    task t_stray;
        logic tv, fv;
        u_master.send_hdr(0);
        see(tv, fv);
        chk({tv, fv}, 2'b00);
        u_master.send_readback(lor_pkg::LOR_CMD_HALF1, cfg.node_address ^ 6'h01);
        see(tv, fv);
        chk({tv, fv}, 2'b01);
        u_master.send_hdr(1);
        see(tv, fv);
        chk({tv, fv}, 2'b00);
    endtask : t_stray

    task t_restrict;
        logic tv, fv;
        logic [7:0] pid;
        cfg.command_restriction_bit = 1'b1;
        apb(1'b1, lor_pkg::LOR_OFS_CFG, {12'h000, cfg});
        u_master.send_readback(lor_pkg::LOR_CMD_HALF2, cfg.node_address);
        u_master.send_hdr(0);
        see(tv, fv);
        chk({tv, fv}, 2'b00);
        for (int i = 0; i < 3; i++) begin
            pid = (i == 0) ? 8'h10 : 8'(i);
            u_master.send_frame(pid, 64'h0123456789ABCDEF, 1'b1);
            see(tv, fv);
            chk({tv, fv}, {1'b0, i != 0});
        end
        chk(fwd_frame.data, 64'h0123456789ABCDEF);
        chk(fwd_frame.pid, 8'h02);
        apb(1'b0, lor_pkg::LOR_OFS_STATUS, 32'h0);
        chk(rd[15:8], 8'h02);
        chk(rd[7:0], 8'h02);
    endtask : t_restrict

    initial begin
        cfg = '{group_number: 4'hA, threshold_control_option: 1'b0,
            modulation_frequency_option: 1'b1, second_lock_bit: 1'b0,
            thermal_warning_level: 1'b1, error_report_disable: 1'b0, default_option: 1'b1,
            diagnostics_disable: 1'b0, slow_bitrate: 1'b1, first_lock_bit: 1'b1,
            command_restriction_bit: 1'b0, node_address: 6'h2A};
        e1 = {8'h13, 8'h12, 8'h11, cfg.first_lock_bit, cfg.command_restriction_bit,
            cfg.node_address, cfg.default_option, cfg.error_report_disable,
            cfg.thermal_warning_level, 5'h1F, 8'hFF, 6'h3F, cfg.slow_bitrate,
            cfg.diagnostics_disable, 2'b11, cfg.node_address};
        e2 = {cfg.second_lock_bit, cfg.modulation_frequency_option, 1'b1,
            cfg.threshold_control_option, cfg.group_number, 8'h33, 8'h32, 8'h31, 8'h23,
            8'h22, 8'h21, 2'b11, cfg.node_address};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_stray;
        t_half(lor_pkg::LOR_CMD_HALF1, 0, e1);
        t_half(lor_pkg::LOR_CMD_HALF2, 3, e2);
        t_restrict;
        end_of_test;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test;
        end
    end
endmodule : tb_lin_otp_settings_readback
